/* File: adcs_params.svh */
// Constants shared by both ends of the converter serial link.
// Assumes a 250 MHz system clock on each end.
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ----------------------------------------
// Widths and control word fields
// ----------------------------------------
`define ADCS_CTRL_W 5
`define ADCS_RES_W 12
`define ADCS_WORD_W 16
`define ADCS_F_SLEEP 0
`define ADCS_F_SW_CONVERT_BIT 1
`define ADCS_F_ADDR 2
`define ADCS_CTRL_RST 5'h00
`define ADCS_TRIG_EDGE 3'h5
`define ADCS_LAST_BIT 4'hf

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCS_CLK_NS 4
`define ADCS_SW_CONVERT_BIT_NS 5900
`define ADCS_SW_CONVERT_BIT_CYC ((`ADCS_SW_CONVERT_BIT_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_ACQ_NS 2000
`define ADCS_ACQ_CYC ((`ADCS_ACQ_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_GAP_NS 500
`define ADCS_GAP_CYC ((`ADCS_GAP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_SCLK_NS 100
`define ADCS_HALF_CYC ((`ADCS_SCLK_NS + 2 * `ADCS_CLK_NS - 1) / (2 * `ADCS_CLK_NS))

// ----------------------------------------
// Host register map
// ----------------------------------------
`define ADCS_A_CTRL 8'h00
`define ADCS_A_CMD 8'h04
`define ADCS_A_MODE 8'h08
`define ADCS_A_STAT 8'h0c
`define ADCS_A_RES 8'h10
`define ADCS_CMD_READ 0
`define ADCS_CMD_START 1

`endif

/* File: adcs_pkg.sv */
// Types shared by both ends of the converter serial link.
// Assumes adcs_params.svh is available on the include path.
`include "adcs_params.svh"

package adcs_pkg;
	typedef logic [`ADCS_CTRL_W-1:0] adcs_ctrl_t;
	typedef logic [`ADCS_WORD_W-1:0] adcs_word_t;
	typedef logic [`ADCS_RES_W-1:0] adcs_res_t;
	typedef logic [11:0] adcs_cnt_t;
	typedef enum logic [1:0] {ADCS_H_IDLE, ADCS_H_HIGH, ADCS_H_LOW} adcs_cs_e;
endpackage

/* File: adcs_link_if.sv */
// Serial link between the converter and its host.
// Two-way clock and frame pins resolve here; an undriven line idles high.
`timescale 1ns/100ps

interface adcs_link_if;
	logic serial_mode_select;
	logic hw_conversion_start;
	logic transmit_frame_sync;
	logic data_in;
	logic serial_result_output;
	logic sclk_host_o;
	logic sclk_host_oe;
	logic sclk_dev_o;
	logic sclk_dev_oe;
	logic sclk;
	logic rfs_host_o;
	logic rfs_host_oe;
	logic rfs_dev_o;
	logic rfs_dev_oe;
	logic receive_frame_sync;

	assign sclk = sclk_dev_oe ? sclk_dev_o :
		(sclk_host_oe ? sclk_host_o : 1'b1);
	assign receive_frame_sync = rfs_dev_oe ? rfs_dev_o :
		(rfs_host_oe ? rfs_host_o : 1'b1);

	modport dev (
		input serial_mode_select, hw_conversion_start, transmit_frame_sync,
		input data_in, sclk, receive_frame_sync,
		output serial_result_output, sclk_dev_o, sclk_dev_oe,
		output rfs_dev_o, rfs_dev_oe
	);
	modport host (
		output serial_mode_select, hw_conversion_start, transmit_frame_sync,
		output data_in, sclk_host_o, sclk_host_oe, rfs_host_o, rfs_host_oe,
		input serial_result_output, sclk, receive_frame_sync
	);
endinterface

/* File: adcs_device.sv */
// Converter end: control word port, conversion timing, result shift-out.
// Assumes link pins are asynchronous to sys_clk; the analog path is modelled
// by a sample word on the user side.
`timescale 1ns/100ps
`include "adcs_params.svh"

module adcs_device
	import adcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	adcs_link_if.dev link,
	input wire adcs_res_t analog_sample,
	output logic [2:0] channel_select,
	output logic sleep_mode,
	output logic track_hold,
	output logic pulse_timing_capacitor,
	output logic sw_convert_bit_done,
	output adcs_res_t last_result
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic ext_mode;
	logic sclk_s;
	logic rfs_n_s;
	logic tfs_n_s;
	logic din_s;
	logic start_s;

	// Reset to the idle pin levels so that no false start edge follows reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1 <= 6'h3c;
			sync2 <= 6'h3c;
		end else begin
			sync1 <= {link.serial_mode_select, link.sclk,
				link.receive_frame_sync, link.transmit_frame_sync,
				link.data_in, link.hw_conversion_start};
			sync2 <= sync1;
		end
	end
	assign {ext_mode, sclk_s, rfs_n_s, tfs_n_s, din_s, start_s} = sync2;

	// ----------------------------------------
	// Serial clock source and edges
	// ----------------------------------------
	logic gen_clk;
	adcs_cnt_t div_cnt;
	logic sclk_lvl;
	logic sclk_prev;
	logic sclk_rise;
	logic sclk_fall;

	always_ff @(posedge sys_clk) begin
		if (rst || ext_mode) begin
			div_cnt <= 12'h000;
			gen_clk <= 1'b1;
		end else if (div_cnt == 12'(`ADCS_HALF_CYC - 1)) begin
			div_cnt <= 12'h000;
			gen_clk <= ~gen_clk;
		end else begin
			div_cnt <= div_cnt + 12'h001;
		end
	end

	assign sclk_lvl = ext_mode ? sclk_s : gen_clk;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sclk_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_lvl;
		end
	end
	assign sclk_rise = sclk_lvl & ~sclk_prev;
	assign sclk_fall = ~sclk_lvl & sclk_prev;

	// ----------------------------------------
	// Control word port
	// ----------------------------------------
	adcs_ctrl_t ctrl;
	logic [3:0] in_shift;
	logic [2:0] edge_cnt;
	logic sixth_edge;

	always_ff @(posedge sys_clk) begin
		if (rst || tfs_n_s) begin
			edge_cnt <= 3'h0;
			in_shift <= 4'h0;
		end else if (sclk_fall && edge_cnt <= `ADCS_TRIG_EDGE) begin
			edge_cnt <= edge_cnt + 3'h1;
			in_shift <= {in_shift[2:0], din_s};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= `ADCS_CTRL_RST;
		end else if (!tfs_n_s && sclk_fall && edge_cnt == 3'h4) begin
			ctrl <= {in_shift, din_s};
		end
	end
	assign sixth_edge = !tfs_n_s && sclk_fall && edge_cnt == `ADCS_TRIG_EDGE;

	assign channel_select = ctrl[`ADCS_F_ADDR +: 3];
	assign sleep_mode = ctrl[`ADCS_F_SLEEP];

	// ----------------------------------------
	// Acquisition pulse and conversion
	// ----------------------------------------
	adcs_cnt_t acq_cnt;
	adcs_cnt_t sw_convert_bit_cnt;
	logic sw_pending;
	logic start_prev;
	logic hw_start;
	logic go;
	adcs_res_t held;
	logic [2:0] held_chan;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acq_cnt <= 12'h000;
		end else if (sixth_edge) begin
			acq_cnt <= 12'(`ADCS_ACQ_CYC);
		end else if (acq_cnt != 12'h000) begin
			acq_cnt <= acq_cnt - 12'h001;
		end
	end
	assign pulse_timing_capacitor = (acq_cnt != 12'h000);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sw_pending <= 1'b0;
		end else if (sixth_edge) begin
			sw_pending <= ctrl[`ADCS_F_SW_CONVERT_BIT];
		end else if (acq_cnt == 12'h001) begin
			sw_pending <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_s;
		end
	end
	assign hw_start = start_s && !start_prev && !ctrl[`ADCS_F_SW_CONVERT_BIT];
	assign go = !sleep_mode && !track_hold &&
		(hw_start || (sw_pending && acq_cnt == 12'h001));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sw_convert_bit_cnt <= 12'h000;
			track_hold <= 1'b0;
			held <= '0;
			held_chan <= 3'h0;
		end else if (go) begin
			sw_convert_bit_cnt <= 12'(`ADCS_SW_CONVERT_BIT_CYC);
			track_hold <= 1'b1;
			held <= analog_sample;
			held_chan <= channel_select;
		end else if (sw_convert_bit_cnt == 12'h001) begin
			sw_convert_bit_cnt <= 12'h000;
			track_hold <= 1'b0;
		end else if (sw_convert_bit_cnt != 12'h000) begin
			sw_convert_bit_cnt <= sw_convert_bit_cnt - 12'h001;
		end
	end

	adcs_word_t out_word;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_result <= '0;
			out_word <= '0;
			sw_convert_bit_done <= 1'b0;
		end else begin
			sw_convert_bit_done <= (sw_convert_bit_cnt == 12'h001);
			if (sw_convert_bit_cnt == 12'h001) begin
				last_result <= held;
				out_word <= {1'b0, held_chan, held};
			end
		end
	end

	// ----------------------------------------
	// Result shift-out
	// ----------------------------------------
	adcs_word_t out_shift;
	logic [3:0] out_cnt;
	logic self_frame_n;
	logic send_pending;
	logic rfs_prev;
	logic framed;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rfs_prev <= 1'b1;
		end else begin
			rfs_prev <= rfs_n_s;
		end
	end

	// A new result arriving as a frame starts keeps its own send request.
	always_ff @(posedge sys_clk) begin
		if (rst || ext_mode) begin
			send_pending <= 1'b0;
		end else if (sw_convert_bit_done) begin
			send_pending <= 1'b1;
		end else if (sclk_rise && self_frame_n) begin
			send_pending <= 1'b0;
		end
	end

	assign framed = ext_mode ? !rfs_n_s : !self_frame_n;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_shift <= '0;
			out_cnt <= 4'h0;
			self_frame_n <= 1'b1;
		end else if (ext_mode) begin
			self_frame_n <= 1'b1;
			out_cnt <= 4'h0;
			if (!rfs_n_s && rfs_prev) begin
				out_shift <= out_word;
			end else if (framed && sclk_rise) begin
				out_shift <= {out_shift[14:0], 1'b0};
			end
		end else if (sclk_rise) begin
			if (!self_frame_n) begin
				out_shift <= {out_shift[14:0], 1'b0};
				out_cnt <= out_cnt + 4'h1;
				if (out_cnt == `ADCS_LAST_BIT) begin
					self_frame_n <= 1'b1;
				end
			end else if (send_pending) begin
				out_shift <= out_word;
				out_cnt <= 4'h0;
				self_frame_n <= 1'b0;
			end
		end
	end

	assign link.serial_result_output = out_shift[15];
	assign link.sclk_dev_o = gen_clk;
	assign link.sclk_dev_oe = !ext_mode;
	assign link.rfs_dev_o = self_frame_n;
	assign link.rfs_dev_oe = !ext_mode;

endmodule

/* File: adcs_host.sv */
// Host end: AXI4-Lite register slave that drives control writes, result
// reads and the hardware start. Assumes device pins arrive asynchronously.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "adcs_params.svh"

module adcs_host
	import adcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	adcs_link_if.host link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_be;
	logic wr_fire;
	logic ext_mode;
	adcs_ctrl_t ctrl_word;
	logic wr_go;
	logic rd_go;
	logic st_go;
	logic wr_busy;
	logic rd_busy;
	logic res_new;
	adcs_word_t result;
	adcs_cs_e cs_state;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_be <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_be <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `ADCS_A_CTRL ||
					aw_addr == `ADCS_A_CMD || aw_addr == `ADCS_A_MODE) ?
					2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	assign wr_go = wr_fire && aw_addr == `ADCS_A_CTRL && w_be;
	assign rd_go = wr_fire && aw_addr == `ADCS_A_CMD && w_be &&
		w_data[`ADCS_CMD_READ];
	assign st_go = wr_fire && aw_addr == `ADCS_A_CMD && w_be &&
		w_data[`ADCS_CMD_START];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_mode <= 1'b1;
			ctrl_word <= `ADCS_CTRL_RST;
		end else if (wr_fire && w_be) begin
			if (aw_addr == `ADCS_A_MODE) begin
				ext_mode <= w_data[0];
			end else if (aw_addr == `ADCS_A_CTRL && !wr_busy) begin
				ctrl_word <= w_data[`ADCS_CTRL_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			if (s_axi_araddr == `ADCS_A_CTRL) begin
				s_axi_rdata <= {27'h0, ctrl_word};
			end else if (s_axi_araddr == `ADCS_A_MODE) begin
				s_axi_rdata <= {31'h0, ext_mode};
			end else if (s_axi_araddr == `ADCS_A_STAT) begin
				s_axi_rdata <= {28'h0, res_new, cs_state != ADCS_H_IDLE,
					rd_busy, wr_busy};
			end else if (s_axi_araddr == `ADCS_A_RES) begin
				s_axi_rdata <= {16'h0, result};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Serial clock and link inputs
	// ----------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic gen_clk;
	adcs_cnt_t div_cnt;
	logic sclk_lvl;
	logic sclk_prev;
	logic sclk_rise;
	logic sclk_fall;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
		end else begin
			sync1 <= {link.sclk, link.receive_frame_sync,
				link.serial_result_output};
			sync2 <= sync1;
		end
	end

	// link clock limit
	// Divider runs in external mode only; 104 ns period keeps the link below 10 MHz.
	always_ff @(posedge sys_clk) begin
		if (rst || !ext_mode) begin
			div_cnt <= 12'h000;
			gen_clk <= 1'b1;
		end else if (div_cnt == 12'(`ADCS_HALF_CYC - 1)) begin
			div_cnt <= 12'h000;
			gen_clk <= ~gen_clk;
		end else begin
			div_cnt <= div_cnt + 12'h001;
		end
	end
	assign sclk_lvl = ext_mode ? gen_clk : sync2[2];
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sclk_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_lvl;
		end
	end
	assign sclk_rise = sclk_lvl & ~sclk_prev;
	assign sclk_fall = ~sclk_lvl & sclk_prev;

	// ----------------------------------------
	// Control write
	// ----------------------------------------
	logic wr_req;
	logic tfs_n;
	adcs_ctrl_t tx_shift;
	logic [2:0] tx_cnt;
	adcs_cnt_t guard;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_req <= 1'b0;
			tfs_n <= 1'b1;
			tx_shift <= '0;
			tx_cnt <= 3'h0;
		end else if (wr_go && !wr_busy) begin
			wr_req <= 1'b1;
		end else if (wr_req && tfs_n && sclk_rise) begin
			tfs_n <= 1'b0;
			tx_shift <= ctrl_word;
			tx_cnt <= 3'h0;
		end else if (!tfs_n && sclk_rise && tx_cnt != 3'h0) begin
			tx_shift <= {tx_shift[3:0], 1'b0};
		end else if (!tfs_n && sclk_fall) begin
			tx_cnt <= tx_cnt + 3'h1;
			if (tx_cnt == `ADCS_TRIG_EDGE) begin
				tfs_n <= 1'b1;
				wr_req <= 1'b0;
			end
		end
	end
	assign wr_busy = wr_req;

	// ----------------------------------------
	// Result read
	// ----------------------------------------
	logic rd_req;
	logic rfs_n;
	logic [4:0] rx_cnt;
	adcs_word_t rx_shift;
	logic rx_frame;

	assign rx_frame = ext_mode ? !rfs_n : !sync2[1];
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_req <= 1'b0;
			rfs_n <= 1'b1;
			rx_cnt <= 5'h00;
			rx_shift <= '0;
			result <= '0;
			res_new <= 1'b0;
		end else begin
			if (rd_go) begin
				rd_req <= 1'b1;
				res_new <= 1'b0;
			end
			if (ext_mode && rd_req && rfs_n && sclk_rise &&
				cs_state != ADCS_H_HIGH) begin
				rfs_n <= 1'b0;
				rx_cnt <= 5'h00;
			end
			if (!rx_frame) begin
				rx_cnt <= 5'h00;
			end else if (sclk_fall) begin
				rx_shift <= {rx_shift[14:0], sync2[0]};
				rx_cnt <= rx_cnt + 5'h01;
				if (rx_cnt == 5'h0f) begin
					result <= {rx_shift[14:0], sync2[0]};
					res_new <= 1'b1;
					rfs_n <= 1'b1;
					rd_req <= 1'b0;
				end
			end
		end
	end
	assign rd_busy = rd_req;

	// ----------------------------------------
	// Hardware start square wave
	// ----------------------------------------
	logic st_req;
	adcs_cnt_t phase_cnt;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			guard <= 12'h000;
		end else if (!tfs_n && sclk_fall && tx_cnt == `ADCS_TRIG_EDGE) begin
			guard <= 12'(`ADCS_ACQ_CYC);
		end else if (rx_frame && sclk_fall && rx_cnt == 5'h0f &&
			guard < 12'(`ADCS_GAP_CYC)) begin
			guard <= 12'(`ADCS_GAP_CYC);
		end else if (guard != 12'h000) begin
			guard <= guard - 12'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_req <= 1'b0;
			cs_state <= ADCS_H_IDLE;
			phase_cnt <= 12'h000;
		end else begin
			if (st_go) begin
				st_req <= 1'b1;
			end
			case (cs_state)
				ADCS_H_IDLE: begin
					// In external mode a waiting read goes first, so no frame opens as start rises.
					if (st_req && guard == 12'h000 && !wr_req &&
						!(ext_mode && rd_req)) begin
						st_req <= st_go;
						cs_state <= ADCS_H_HIGH;
						phase_cnt <= 12'(`ADCS_SW_CONVERT_BIT_CYC - 1);
					end
				end
				ADCS_H_HIGH: begin
					if (phase_cnt == 12'h000) begin
						cs_state <= ADCS_H_LOW;
						phase_cnt <= 12'(`ADCS_SW_CONVERT_BIT_CYC - 1);
					end else begin
						phase_cnt <= phase_cnt - 12'h001;
					end
				end
				default: begin
					if (phase_cnt == 12'h000) begin
						cs_state <= ADCS_H_IDLE;
					end else begin
						phase_cnt <= phase_cnt - 12'h001;
					end
				end
			endcase
		end
	end

	assign link.serial_mode_select = ext_mode;
	assign link.hw_conversion_start = (cs_state == ADCS_H_HIGH);
	assign link.transmit_frame_sync = tfs_n;
	assign link.data_in = tx_shift[`ADCS_CTRL_W-1];
	assign link.sclk_host_o = gen_clk;
	assign link.sclk_host_oe = ext_mode;
	assign link.rfs_host_o = rfs_n;
	assign link.rfs_host_oe = ext_mode;

endmodule

/* File: adcs_link_properties.sv */
// Checker on the converter link wires between host and device ends.
// Assumes each input is wired to the link signal of the same name.
`timescale 1ns/100ps

module adcs_link_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serial_mode_select,
	input wire logic hw_conversion_start,
	input wire logic transmit_frame_sync,
	input wire logic serial_result_output,
	input wire logic sclk_host_oe,
	input wire logic sclk_dev_oe,
	input wire logic rfs_dev_oe,
	input wire logic sclk,
	input wire logic receive_frame_sync
);
	logic [3:0] wr_falls;
	logic [9:0] since_trig;
	logic [7:0] since_rd;
	logic [4:0] half;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// The since_trig, since_rd and half counters saturate so that a long idle spell never wraps round.
	always_ff @(posedge sys_clk) begin
		if (rst || $fell(transmit_frame_sync))
			wr_falls <= 4'h0;
		else if (!transmit_frame_sync && $fell(sclk))
			wr_falls <= wr_falls + 4'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst)
			since_trig <= 10'h3ff;
		else if (!transmit_frame_sync && $fell(sclk) && wr_falls == 4'h5)
			since_trig <= 10'h000;
		else if (since_trig != 10'h3ff)
			since_trig <= since_trig + 10'h001;
	end
	always_ff @(posedge sys_clk) begin
		if (rst)
			since_rd <= 8'hff;
		else if ($rose(receive_frame_sync))
			since_rd <= 8'h00;
		else if (since_rd != 8'hff)
			since_rd <= since_rd + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (rst || $changed(sclk))
			half <= 5'h00;
		else if (half != 5'h1f)
			half <= half + 5'h01;
	end

	sequence s_wr_end;
		$rose(transmit_frame_sync);
	endsequence
	sequence s_ext_held;
		serial_mode_select [*8];
	endsequence
	sequence s_self_held;
		!serial_mode_select [*8];
	endsequence

	a_ext_pins_in: assert property (
		s_ext_held |-> !sclk_dev_oe && !rfs_dev_oe)
		else $error("device drives clock or frame in external mode");
	a_self_clk_out: assert property (
		s_self_held |-> sclk_dev_oe && !sclk_host_oe)
		else $error("device does not own the clock in self mode");
	a_write_six_falls: assert property (
		s_wr_end |-> wr_falls == 4'h6)
		else $error("control frame closed after wrong fall count");
	a_out_hold: assert property (
		$fell(sclk) && !receive_frame_sync |=>
		$stable(serial_result_output) [*2])
		else $error("result bit moved just after a falling clock");
	a_acq_gap: assert property (
		$rose(hw_conversion_start) |-> since_trig >= 10'd500)
		else $error("start came too soon after a channel write");
	a_read_gap: assert property (
		$rose(hw_conversion_start) |-> since_rd >= 8'd125)
		else $error("start came too soon after a result read");
	a_read_quiet: assert property (
		$fell(receive_frame_sync) && serial_mode_select |->
		!hw_conversion_start)
		else $error("result read began while start was high");
	a_sclk_rate: assert property (
		$changed(sclk) && serial_mode_select && !sclk_dev_oe &&
		(!transmit_frame_sync || !receive_frame_sync) |-> half >= 5'd12)
		else $error("host serial clock phase too short");
endmodule

/* File: tb_top.sv */
// Testbench: host and device ends joined by the link, host driven over AXI.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/100ps
`include "adcs_params.svh"

module tb_top
	import adcs_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	adcs_res_t analog_sample = 12'h000, last_result, smp;
	logic [2:0] channel_select;
	logic sleep_mode, track_hold, pulse_timing_capacitor, sw_convert_bit_done;
	logic pulse_seen = 0, hw_prev = 0;
	int mismatches = 0, compares = 0, seed = 60664, lat = 0, lat_done = 0;
	int exp_q[$];
	int hold_len = 0;

	adcs_link_if link();
	adcs_device i_adcs_device (.sys_clk, .rst, .link(link), .analog_sample,
		.channel_select, .sleep_mode, .track_hold, .pulse_timing_capacitor,
		.sw_convert_bit_done, .last_result);
	adcs_host i_adcs_host (.sys_clk, .rst, .link(link), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	adcs_link_properties i_props (.sys_clk, .rst,
		.serial_mode_select(link.serial_mode_select),
		.hw_conversion_start(link.hw_conversion_start),
		.transmit_frame_sync(link.transmit_frame_sync),
		.serial_result_output(link.serial_result_output),
		.sclk_host_oe(link.sclk_host_oe), .sclk_dev_oe(link.sclk_dev_oe),
		.rfs_dev_oe(link.rfs_dev_oe), .sclk(link.sclk),
		.receive_frame_sync(link.receive_frame_sync));

	always #2 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Handshakes are judged at the falling edge, where all levels have settled.
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		aw = 0;
		w = 0;
		b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge sys_clk);
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, v;
		ar = 0;
		v = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v) begin
			@(negedge sys_clk);
			ar = ar | (s_axi_arvalid & s_axi_arready);
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic drain();
		int t;
		t = 0;
		while (exp_q.size() != 0 && t < 5000) begin
			@(negedge sys_clk);
			t++;
		end
		@(posedge sys_clk);
		chk("pending conversions", 0, exp_q.size());
	endtask

	// Software start on channel c; cmd 0 means the device frames the result.
	task automatic sw_sw_convert_bit(input int c, input logic [31:0] cmd);
		int t;
		t = 0;
		smp = adcs_res_t'($random(seed));
		analog_sample <= smp;
		exp_q.push_back(smp);
		pulse_seen = 0;
		axw(`ADCS_A_CTRL, {27'h0, c[2:0], 2'b10}, rs);
		drain();
		chk("channel", c[2:0], channel_select);
		chk("acquisition pulse", 1, pulse_seen);
		if (cmd == 0) repeat (16 * 26 + 50) @(posedge sys_clk);
		else axw(`ADCS_A_CMD, cmd, rs);
		do begin
			axr(`ADCS_A_STAT, rd, rs);
			t++;
		end while ((rd & 32'ha) !== 32'h8 && t < 2000);
		axr(`ADCS_A_RES, rd, rs);
		chk("result word", {17'h0, c[2:0], smp}, rd);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Reference model of conversions
	// ----------------------------------------
	always @(negedge sys_clk) begin
		if (pulse_timing_capacitor === 1'b1) pulse_seen = 1;
		if (track_hold === 1'b1) hold_len++;
		lat = (link.hw_conversion_start === 1'b1 && hw_prev !== 1'b1) ? 0 : lat + 1;
		hw_prev = link.hw_conversion_start;
		if (sw_convert_bit_done === 1'b1) begin
			lat_done = lat;
			chk("hold length", `ADCS_SW_CONVERT_BIT_CYC, hold_len);
			hold_len = 0;
			if (exp_q.size() == 0) chk("unexpected conversion", 0, 1);
			else chk("conversion result", exp_q.pop_front(), last_result);
		end
	end

	initial begin
		repeat (95000) @(posedge sys_clk);
		mismatches++;
		$display("watchdog expired");
		final_report();
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		axr(`ADCS_A_MODE, rd, rs);
		chk("mode after reset", 32'h1, rd);
		axr(`ADCS_A_STAT, rd, rs);
		chk("status after reset", 32'h0, rd);
		chk("sleep after reset", 0, sleep_mode);
		axr(8'h14, rd, rs);
		chk("unmapped read", 2'h2, rs);
		axw(8'h14, 32'h1f, rs);
		chk("unmapped write", 2'h2, rs);
		$display("test reset done");
		for (int m = 0; m < 2; m++) begin
			axw(`ADCS_A_MODE, m, rs);
			for (int c = 0; c < 8; c += 2 - m)
				sw_sw_convert_bit(c, m);
		end
		$display("test software start done");
		smp = adcs_res_t'($random(seed));
		analog_sample <= smp;
		exp_q.push_back(smp);
		axw(`ADCS_A_CTRL, {27'h0, 3'h5, 2'b00}, rs);
		axw(`ADCS_A_CMD, 32'h2, rs);
		drain();
		axw(`ADCS_A_CMD, 32'h0, rs);
		chk("start to result", 1, lat_done >= 1476 && lat_done <= 1482);
		$display("test hardware start done");
		axw(`ADCS_A_CTRL, {27'h0, 3'h1, 2'b01}, rs);
		do begin
			axr(`ADCS_A_STAT, rd, rs);
		end while (rd[0] !== 1'b0);
		chk("sleep set", 1, sleep_mode);
		axw(`ADCS_A_CMD, 32'h2, rs);
		repeat (6000) @(posedge sys_clk);
		sw_sw_convert_bit(2, 32'h3);
		chk("sleep cleared", 0, sleep_mode);
		repeat (6000) @(posedge sys_clk);
		axw(`ADCS_A_CMD, 32'h0, rs);
		$display("test sleep and start lockout done");
		final_report();
	end
endmodule
